// [src/cit_instr_seq.v]
// Instruction fetch and timing sequencer of the 8-bit core.
// Assumes zero-wait code memory and port latches read in the same cycle.
`timescale 1ns/10ps
`default_nettype none
`include "cit_defines.vh"

module cit_instr_seq (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_b_i,
  // Code memory
  output wire [15:0] code_addr_o,
  input wire [7:0] code_data_i,
  // Program flow from the execute datapath
  input wire redirect_i,
  input wire [15:0] redirect_pc_i,
  // Bit and port operands
  input wire port_hit_i,
  input wire [7:0] port_latch_i,
  input wire [7:0] port_pin_i,
  input wire bit_val_i,
  input wire carry_i,
  // Sequencing status
  output wire fetch_o,
  output wire done_o,
  output wire [7:0] opcode_o,
  output wire [7:0] oper1_o,
  output wire [7:0] oper2_o,
  output wire [3:0] cycle_o,
  output wire [1:0] ins_bytes_o,
  output wire [3:0] ins_cycles_o,
  output wire unknown_o,
  // Port and bit results
  output wire [7:0] bit_addr_o,
  output wire [7:0] port_rd_data_o,
  output wire port_wr_o,
  output wire [7:0] port_wr_data_o,
  output wire bit_wr_o,
  output wire bit_wr_val_o,
  output wire branch_o
);

  // ========================================================================
  // State
  reg st_q;
  reg st_d;
  reg [15:0] pc_q;
  reg [15:0] pc_d;
  reg [3:0] cyc_q;
  reg [3:0] cyc_d;
  reg [7:0] op_q;
  reg [7:0] a1_q;
  reg [7:0] a2_q;
  reg [1:0] nb_q;
  reg [3:0] nc_q;
  reg rmw_q;
  reg bw_q;
  reg [1:0] bop_q;
  reg unk_q;
  reg ex_q;
  reg ex_d;
  reg [1:0] ex_bop_q;
  reg [7:0] rd_q;
  reg pw_q;
  reg [7:0] pwd_q;
  reg bwr_q;
  reg bwv_q;
  reg br_q;

  // ========================================================================
  // Decode of the byte on the code bus
  wire [1:0] dec_bytes;
  wire [3:0] dec_cycles;
  wire dec_rmw;
  wire dec_bitwr;
  wire [1:0] dec_bop;
  wire dec_known;

  cit_op_decode u_dec (
    .opcode_i(code_data_i),
    .bytes_o(dec_bytes),
    .cycles_o(dec_cycles),
    .rmw_o(dec_rmw),
    .bitwr_o(dec_bitwr),
    .bop_o(dec_bop),
    .known_o(dec_known)
  );

  // ========================================================================
  // Current instruction view
  wire run = (st_q == `CIT_ST_RUN);
  wire first = run && (cyc_q == 4'h0);
  wire [1:0] cur_bytes = first ? dec_bytes : nb_q;
  wire [3:0] cur_cycles = first ? dec_cycles : nc_q;
  wire fetch_now = run && (cyc_q < {2'h0, cur_bytes});
  wire last = run && (cyc_q == cur_cycles - 4'h1);
  wire is_bit_jmp = (op_q == `CIT_OP_JMP_BIT_CLR);

  // ========================================================================
  // Port access path
  wire [7:0] rmw_rd;
  wire rmw_old;
  wire rmw_new;
  wire [7:0] rmw_wr;
  wire [1:0] use_bop = ex_q ? ex_bop_q : bop_q;

  cit_port_rmw u_rmw (
    .latch_i(port_latch_i),
    .pin_i(port_pin_i),
    .port_hit_i(port_hit_i),
    .rmw_i(rmw_q | ex_q),
    .bit_idx_i(a1_q[`CIT_BIT_IDX_MSB:`CIT_BIT_IDX_LSB]),
    .bop_i(use_bop),
    .carry_i(carry_i),
    .ext_bit_i(bit_val_i),
    .rd_byte_o(rmw_rd),
    .old_bit_o(rmw_old),
    .new_bit_o(rmw_new),
    .wr_byte_o(rmw_wr)
  );

  // Bit jump decides at its last cycle, operands already captured
  wire bit_jmp_take = last && !first && is_bit_jmp && rmw_old;

  // ========================================================================
  // Relative target from the trailing offset byte
  function [15:0] rel_target;
    input [15:0] base;
    input [7:0] rel;
    begin
      rel_target = base + {{8{rel[7]}}, rel};
    end
  endfunction

  wire [15:0] pc_inc = pc_q + {15'h0000, fetch_now};

  // ========================================================================
  // Next state
  always @*
  begin
    st_d = st_q;
    cyc_d = cyc_q;
    pc_d = pc_q;
    ex_d = 1'b0;
    case (st_q)
      `CIT_ST_BOOT:
      begin
        st_d = `CIT_ST_RUN;
        cyc_d = 4'h0;
      end
      `CIT_ST_RUN:
      begin
        pc_d = pc_inc;
        if (last)
        begin
          cyc_d = 4'h0;
          if (bit_jmp_take)
          begin
            pc_d = rel_target(pc_inc, a2_q);
          end
          else if (redirect_i)
          begin
            pc_d = redirect_pc_i;
          end
          // Bit writes land in the stage after the last cycle
          if (first)
          begin
            ex_d = dec_bitwr;
          end
          else if (is_bit_jmp)
          begin
            ex_d = bit_jmp_take;
          end
          else
          begin
            ex_d = bw_q;
          end
        end
        else
        begin
          cyc_d = cyc_q + 4'h1;
        end
      end
      default:
      begin
        st_d = `CIT_ST_BOOT;
        cyc_d = 4'h0;
      end
    endcase
  end

  // ========================================================================
  // Sequencer registers
  always @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= `CIT_ST_BOOT;
      pc_q <= `CIT_RESET_PC;
      cyc_q <= 4'h0;
      ex_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      pc_q <= pc_d;
      cyc_q <= cyc_d;
      ex_q <= ex_d;
    end
  end

  // ========================================================================
  // Instruction capture
  always @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      op_q <= `CIT_RESET_BYTE;
      a1_q <= `CIT_RESET_BYTE;
      a2_q <= `CIT_RESET_BYTE;
      nb_q <= 2'h1;
      nc_q <= 4'h1;
      rmw_q <= 1'b0;
      bw_q <= 1'b0;
      bop_q <= `CIT_BOP_CLR;
      unk_q <= 1'b0;
      ex_bop_q <= `CIT_BOP_CLR;
    end
    else
    begin
      if (first)
      begin
        op_q <= code_data_i;
        nb_q <= dec_bytes;
        nc_q <= dec_cycles;
        rmw_q <= dec_rmw;
        bw_q <= dec_bitwr;
        bop_q <= dec_bop;
        unk_q <= ~dec_known;
      end
      if (fetch_now && (cyc_q == 4'h1))
      begin
        a1_q <= code_data_i;
      end
      if (fetch_now && (cyc_q == 4'h2))
      begin
        a2_q <= code_data_i;
      end
      if (last)
      begin
        ex_bop_q <= first ? dec_bop : bop_q;
      end
    end
  end

  // ========================================================================
  // Port and bit results
  always @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      rd_q <= `CIT_RESET_BYTE;
      pw_q <= 1'b0;
      pwd_q <= `CIT_RESET_BYTE;
      bwr_q <= 1'b0;
      bwv_q <= 1'b0;
      br_q <= 1'b0;
    end
    else
    begin
      rd_q <= rmw_rd;
      pw_q <= ex_q && port_hit_i;
      bwr_q <= ex_q && !port_hit_i;
      br_q <= bit_jmp_take;
      if (ex_q)
      begin
        pwd_q <= rmw_wr;
        bwv_q <= rmw_new;
      end
    end
  end

  // ========================================================================
  // Outputs
  assign code_addr_o = pc_q;
  assign fetch_o = first;
  assign done_o = last;
  assign opcode_o = op_q;
  assign oper1_o = a1_q;
  assign oper2_o = a2_q;
  assign cycle_o = cyc_q;
  assign ins_bytes_o = nb_q;
  assign ins_cycles_o = nc_q;
  assign unknown_o = unk_q;
  assign bit_addr_o = a1_q;
  assign port_rd_data_o = rd_q;
  assign port_wr_o = pw_q;
  assign port_wr_data_o = pwd_q;
  assign bit_wr_o = bwr_q;
  assign bit_wr_val_o = bwv_q;
  assign branch_o = br_q;

endmodule // cit_instr_seq

`default_nettype wire

// [src/cit_defines.vh]
// Constants for the instruction sequencing block: opcodes, bit operations, states.
// Assumes an 8-bit core with a 16-bit code address and zero-wait memories.
`ifndef CIT_DEFINES_VH
`define CIT_DEFINES_VH

// ==========================================================================
// Reset values
`define CIT_RESET_PC 16'h0000
`define CIT_RESET_BYTE 8'h00

// ==========================================================================
// Sequencer states
`define CIT_ST_BOOT 1'b0
`define CIT_ST_RUN 1'b1

// ==========================================================================
// Bit operation codes for port bit writes
`define CIT_BOP_CLR 2'h0
`define CIT_BOP_SET 2'h1
`define CIT_BOP_INV 2'h2
`define CIT_BOP_CARRY 2'h3

// ==========================================================================
// Opcodes needing individual treatment
`define CIT_OP_JMP_BIT_CLR 8'h10
`define CIT_OP_CLR_BIT 8'hC2
`define CIT_OP_SET_BIT 8'hD2
`define CIT_OP_INV_BIT 8'hB2
`define CIT_OP_MOV_BIT_C 8'h92
`define CIT_OP_AND_DIR_A 8'h52
`define CIT_OP_AND_DIR_IMM 8'h53
`define CIT_OP_OR_DIR_A 8'h42
`define CIT_OP_OR_DIR_IMM 8'h43
`define CIT_OP_XOR_DIR_A 8'h62
`define CIT_OP_XOR_DIR_IMM 8'h63
`define CIT_OP_INC_DIR 8'h05
`define CIT_OP_DEC_DIR 8'h15
`define CIT_OP_DEC_BRANCH_DIR 8'hD5

// ==========================================================================
// Bit address field: low three bits select the bit within the byte
`define CIT_BIT_IDX_MSB 2
`define CIT_BIT_IDX_LSB 0

`endif

// [src/cit_op_decode.v]
// Opcode decoder: encoded length, execution cycles and port access class.
// Purely combinational; the opcode byte comes straight from code memory.
`timescale 1ns/10ps
`default_nettype none
`include "cit_defines.vh"

module cit_op_decode (
  // Opcode in
  input wire [7:0] opcode_i,
  // Decoded attributes
  output reg [1:0] bytes_o,
  output reg [3:0] cycles_o,
  output reg rmw_o,
  output reg bitwr_o,
  output reg [1:0] bop_o,
  output reg known_o
);

  // ========================================================================
  // Length and timing table
  always @*
  begin
    bytes_o = 2'h1;
    cycles_o = 4'h1;
    known_o = 1'b1;
    casez (opcode_i)
      8'h00, 8'h03, 8'h13, 8'h23, 8'h33: cycles_o = 4'h1;
      8'b1110_1???, 8'b1111_1???, 8'b1100_1???: cycles_o = 4'h1;
      8'hC3, 8'hD3, 8'hB3: cycles_o = 4'h1;
      8'b1110_011?, 8'b1111_011?, 8'b1100_011?, 8'b1101_011?: cycles_o = 4'h2;
      8'hE5, 8'h74, 8'b0111_1???, 8'hF5, 8'b1010_1???, 8'b1000_1???,
      8'b0111_011?, 8'b1000_011?, 8'b1010_011?:
      begin
        bytes_o = 2'h2;
        cycles_o = 4'h2;
      end
      8'hC0, 8'hD0, 8'hC5, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92,
      8'h52, 8'h42, 8'h62, 8'h05, 8'h15:
      begin
        bytes_o = 2'h2;
        cycles_o = 4'h2;
      end
      8'h85, 8'h75, 8'h90, 8'h53, 8'h43, 8'h63:
      begin
        bytes_o = 2'h3;
        cycles_o = 4'h3;
      end
      8'h93, 8'h83, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: cycles_o = 4'h4;
      8'h73: cycles_o = 4'h3;
      8'h22, 8'h32: cycles_o = 4'h4;
      8'b???1_0001, 8'b???0_0001, 8'h80, 8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???:
      begin
        bytes_o = 2'h2;
        cycles_o = 4'h3;
      end
      8'h02, 8'h12, 8'h20, 8'h30, 8'h10, 8'hB4, 8'hB5, 8'b1011_011?, 8'b1011_1???, 8'hD5:
      begin
        bytes_o = 2'h3;
        cycles_o = 4'h4;
      end
      default: known_o = 1'b0;
    endcase
  end

  // ========================================================================
  // Port destination class
  always @*
  begin
    rmw_o = 1'b0;
    bitwr_o = 1'b0;
    bop_o = `CIT_BOP_CLR;
    case (opcode_i)
      `CIT_OP_AND_DIR_A, `CIT_OP_AND_DIR_IMM, `CIT_OP_OR_DIR_A, `CIT_OP_OR_DIR_IMM,
      `CIT_OP_XOR_DIR_A, `CIT_OP_XOR_DIR_IMM, `CIT_OP_INC_DIR, `CIT_OP_DEC_DIR,
      `CIT_OP_DEC_BRANCH_DIR: rmw_o = 1'b1;
      `CIT_OP_JMP_BIT_CLR, `CIT_OP_CLR_BIT:
      begin
        rmw_o = 1'b1;
        bitwr_o = 1'b1;
      end
      `CIT_OP_SET_BIT:
      begin
        rmw_o = 1'b1;
        bitwr_o = 1'b1;
        bop_o = `CIT_BOP_SET;
      end
      `CIT_OP_INV_BIT:
      begin
        rmw_o = 1'b1;
        bitwr_o = 1'b1;
        bop_o = `CIT_BOP_INV;
      end
      `CIT_OP_MOV_BIT_C:
      begin
        rmw_o = 1'b1;
        bitwr_o = 1'b1;
        bop_o = `CIT_BOP_CARRY;
      end
      default: rmw_o = 1'b0;
    endcase
  end

endmodule // cit_op_decode

`default_nettype wire

// [src/cit_port_rmw.v]
// Port access path: picks pin or latch and merges a single bit write.
// Combinational; the caller registers whatever leaves the block.
`timescale 1ns/10ps
`default_nettype none
`include "cit_defines.vh"

module cit_port_rmw (
  // Port state
  input wire [7:0] latch_i,
  input wire [7:0] pin_i,
  input wire port_hit_i,
  // Operation
  input wire rmw_i,
  input wire [2:0] bit_idx_i,
  input wire [1:0] bop_i,
  input wire carry_i,
  input wire ext_bit_i,
  // Results
  output wire [7:0] rd_byte_o,
  output wire old_bit_o,
  output wire new_bit_o,
  output reg [7:0] wr_byte_o
);

  // ========================================================================
  // Source select
  assign rd_byte_o = rmw_i ? latch_i : pin_i;
  assign old_bit_o = port_hit_i ? latch_i[bit_idx_i] : ext_bit_i;
  assign new_bit_o = (bop_i == `CIT_BOP_SET) ? 1'b1 :
                     (bop_i == `CIT_BOP_INV) ? ~old_bit_o :
                     (bop_i == `CIT_BOP_CARRY) ? carry_i : 1'b0;

  // ========================================================================
  // Whole byte write back, one bit changed
  always @*
  begin
    wr_byte_o = latch_i;
    wr_byte_o[bit_idx_i] = new_bit_o;
  end

endmodule // cit_port_rmw

`default_nettype wire

// [test/cit_far_side.sv]
// Far-side model: code memory, port output latch and port select.
// Assumes code reads answer in the same cycle and latch writes land on clk.
`timescale 1ns/10ps
`default_nettype none
module cit_far_side #(
  parameter logic [7:0] LATCH_RST = 8'h5A
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Core side
  input wire logic [15:0] code_addr_i,
  input wire logic [7:0] bit_addr_i,
  input wire logic port_wr_i,
  input wire logic [7:0] port_wr_data_i,
  // Answers
  output logic [7:0] code_data_o,
  output logic port_hit_o,
  output logic [7:0] port_latch_o
);
  logic [7:0] code_q [0:4095];
  assign code_data_o = code_q[code_addr_i[11:0]];
  // Upper half of the map holds the ports
  assign port_hit_o = bit_addr_i[7];
  always @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      port_latch_o <= LATCH_RST;
    else if (port_wr_i)
      port_latch_o <= port_wr_data_i;
  end
endmodule // cit_far_side
`default_nettype wire

// [test/cit_instr_seq_sva.sv]
// Checker for the sequencer: fetch timing and port bit writes.
// Sees only the top module's ports; attached by the bind below.
`timescale 1ns/10ps
`default_nettype none
module cit_instr_seq_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Fetch and timing
  input wire logic [15:0] code_addr_o,
  input wire logic [7:0] code_data_i,
  input wire logic fetch_o,
  input wire logic done_o,
  input wire logic [1:0] ins_bytes_o,
  input wire logic [3:0] ins_cycles_o,
  // Port writes
  input wire logic [7:0] port_latch_i,
  input wire logic port_wr_o,
  input wire logic [7:0] port_wr_data_o,
  input wire logic branch_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  next_fetch_a: assert property (done_o |=> fetch_o)
    else $error("No fetch after last cycle");
  pc_step_a: assert property (fetch_o |=> code_addr_o == $past(code_addr_o) + 16'h0001)
    else $error("Address did not step after opcode");
  rotate_len_a: assert property (fetch_o && code_data_i == 8'h33 |-> done_o ##1 fetch_o)
    else $error("Rotate not one cycle");
  code_load_a: assert property (fetch_o && code_data_i == 8'h93 |-> !done_o [*3] ##1 done_o)
    else $error("Code byte load not four cycles");
  ext_move_a: assert property (fetch_o && code_data_i == 8'hE0 |-> ##3 done_o ##1 fetch_o)
    else $error("Extended move not four cycles");
  long_len_a: assert property (fetch_o && code_data_i == 8'h02 |=>
    (ins_bytes_o == 2'h3 && ins_cycles_o == 4'h4) ##3 fetch_o)
    else $error("Long jump length wrong");
  wr_onebit_a: assert property (port_wr_o |-> $onehot0(port_wr_data_o ^ $past(port_latch_i)))
    else $error("Port write changed more than one bit");
  wr_timing_a: assert property (port_wr_o |-> $past(done_o, 2))
    else $error("Port write not two cycles after done");
  branch_fetch_a: assert property (branch_o |-> fetch_o && $past(done_o))
    else $error("Branch pulse not at next fetch");
endmodule // cit_instr_seq_chk
bind cit_instr_seq cit_instr_seq_chk chk_u (
  .clk_sys_i,
  .rst_b_i,
  .code_addr_o,
  .code_data_i,
  .fetch_o,
  .done_o,
  .ins_bytes_o,
  .ins_cycles_o,
  .port_latch_i,
  .port_wr_o,
  .port_wr_data_o,
  .branch_o
);
`default_nettype wire

// [test/cit_instr_seq_tb.sv]
// Bench for the sequencer: timing table, port reads, bit writes.
// Assumes the far-side model holds code memory and the port latch.
`timescale 1ns/10ps
`default_nettype none
`include "cit_defines.vh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module cit_instr_seq_tb;
  // ==========================================================================
  // Signals and expectations
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic carry_i = 1'b0;
  logic bit_val_i = 1'b0;
  logic [7:0] pin = 8'h00;
  wire [15:0] code_addr;
  wire [7:0] code_data, bit_addr, rd_data, wr_data, lat;
  wire fetch, done, port_wr, bit_wr, wr_val, branch, hit;
  wire [1:0] ins_bytes;
  wire [3:0] ins_cycles, cyc_idx;
  wire [7:0] opc, opr1;
  wire unk;
  int err_total = 0;
  int n_tests = 0;
  int k = -1;
  int cnt = 0;
  int nbr = 0;
  int nbr_seen = 0;
  logic [15:0] pc = 16'h0000;
  logic [7:0] lat_exp = 8'h5A;
  logic [7:0] ev;
  logic [15:0] qa[$];
  logic [1:0] qb[$], qr[$];
  logic [3:0] qc[$];
  logic [7:0] pw_q[$];
  logic bw_q[$];
  logic [7:0] bops [4] = '{`CIT_OP_CLR_BIT, `CIT_OP_SET_BIT, `CIT_OP_INV_BIT, `CIT_OP_MOV_BIT_C};
  // Opcode, bytes, cycles
  logic [15:0] tbl [67] = '{16'h3311, 16'h0311, 16'h1311,
    16'hE811, 16'hF811, 16'hE612, 16'hF612,
    16'hE522, 16'h7422, 16'h7822, 16'hF522, 16'hA822, 16'h8822, 16'h7622, 16'h8622, 16'hA622,
    16'h8533, 16'h7533, 16'h9033, 16'h9314, 16'h8314,
    16'hE214, 16'hE014, 16'hF214, 16'hF014, 16'hC022, 16'hD022,
    16'hC811, 16'hC612, 16'hD612, 16'hC522, 16'hC311, 16'hD311, 16'hB311,
    16'h8222, 16'hB022, 16'h7222, 16'hA022, 16'hA222, 16'h7313, 16'h2214, 16'h3214,
    16'h1123, 16'h0123, 16'h8023, 16'h4023, 16'h5023, 16'h6023, 16'h7023, 16'hD823,
    16'h0234, 16'h1234, 16'h2034, 16'h3034, 16'hB534, 16'hB434, 16'hB834, 16'hB634, 16'hD534,
    16'h5222, 16'h5333, 16'h4222, 16'h4333, 16'h6222, 16'h6333, 16'h0522, 16'h1522};
  always #12.5 clk_sys_i = ~clk_sys_i;
  cit_instr_seq dut (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .code_addr_o(code_addr),
    .code_data_i(code_data),
    .redirect_i(1'b0),
    .redirect_pc_i(16'h0000),
    .port_hit_i(hit),
    .port_latch_i(lat),
    .port_pin_i(pin),
    .bit_val_i(bit_val_i),
    .carry_i(carry_i),
    .fetch_o(fetch),
    .done_o(done),
    .opcode_o(opc),
    .oper1_o(opr1),
    .oper2_o(),
    .cycle_o(cyc_idx),
    .ins_bytes_o(ins_bytes),
    .ins_cycles_o(ins_cycles),
    .unknown_o(unk),
    .bit_addr_o(bit_addr),
    .port_rd_data_o(rd_data),
    .port_wr_o(port_wr),
    .port_wr_data_o(wr_data),
    .bit_wr_o(bit_wr),
    .bit_wr_val_o(wr_val),
    .branch_o(branch)
  );
  cit_far_side far (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .code_addr_i(code_addr),
    .bit_addr_i(bit_addr),
    .port_wr_i(port_wr),
    .port_wr_data_i(wr_data),
    .code_data_o(code_data),
    .port_hit_o(hit),
    .port_latch_o(lat)
  );
  // ==========================================================================
  // Monitor
  always @(posedge clk_sys_i)
  begin
    if (rst_b_i)
    begin
      if (cnt == 2 && k >= 0 && k < qa.size() && qb[k] > 2'h1)
        `CHK("operand", far.code_q[qa[k][11:0] + 12'h001], opr1)
      if (cnt == 1 && k >= 0 && k < qa.size())
      begin
        `CHK("bytes", qb[k], ins_bytes)
        `CHK("cycles", qc[k], ins_cycles)
        `CHK("opcode", far.code_q[qa[k][11:0]], opc)
        `CHK("unknown", far.code_q[qa[k][11:0]] == 8'hA5, unk)
        `CHK("cycle idx", (qc[k] > 4'h1) ? 4'h1 : 4'h0, cyc_idx)
        if (k > 0 && qr[k - 1] != 2'h0)
          `CHK("port read", (qr[k - 1] == 2'h1) ? lat : pin, rd_data)
      end
      if (fetch)
      begin
        if (k >= 0 && k < qa.size())
          `CHK("length", qc[k], cnt)
        k++;
        cnt = 1;
        if (k < qa.size())
          `CHK("fetch addr", qa[k], code_addr)
      end
      else
        cnt++;
      if (port_wr)
      begin
        ev = (pw_q.size() > 0) ? pw_q.pop_front() : ~wr_data;
        `CHK("port byte", ev, wr_data)
      end
      if (bit_wr)
      begin
        ev = (bw_q.size() > 0) ? {7'h00, bw_q.pop_front()} : 8'hFF;
        `CHK("bit value", ev, {7'h00, wr_val})
      end
      if (branch)
        nbr_seen++;
    end
  end
  // ==========================================================================
  // Program building
  task automatic emit(input logic [7:0] op, b1, b2, input logic [1:0] nb, rd,
    input logic [3:0] nc);
    far.code_q[pc[11:0]] = op;
    far.code_q[pc[11:0] + 12'h001] = b1;
    far.code_q[pc[11:0] + 12'h002] = b2;
    qa.push_back(pc);
    qb.push_back(nb);
    qc.push_back(nc);
    qr.push_back(rd);
    pc = pc + {14'h0000, nb};
  endtask
  task automatic wr_exp(input logic [7:0] adr, input logic nv);
    if (adr[7])
    begin
      lat_exp[adr[2:0]] = nv;
      pw_q.push_back(lat_exp);
    end
    else
      bw_q.push_back(nv);
  endtask
  task automatic bitop(input logic [7:0] op, adr);
    logic cur;
    cur = adr[7] ? lat_exp[adr[2:0]] : bit_val_i;
    emit(op, adr, 8'h00, 2'h2, 2'h0, 4'h2);
    case (op)
      `CIT_OP_CLR_BIT: wr_exp(adr, 1'b0);
      `CIT_OP_SET_BIT: wr_exp(adr, 1'b1);
      `CIT_OP_INV_BIT: wr_exp(adr, ~cur);
      default: wr_exp(adr, carry_i);
    endcase
  endtask
  task automatic bit_jump(input logic [7:0] adr);
    logic cur;
    cur = adr[7] ? lat_exp[adr[2:0]] : bit_val_i;
    emit(`CIT_OP_JMP_BIT_CLR, adr, 8'h04, 2'h3, 2'h0, 4'h4);
    if (cur)
    begin
      pc = pc + 16'h0004;
      nbr++;
      wr_exp(adr, 1'b0);
    end
  endtask
  task automatic give_verdict;
    `CHK("branches", nbr, nbr_seen)
    `CHK("writes left", 0, pw_q.size() + bw_q.size())
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic run_to(input int n, input string nm);
    for (int i = 0; i < 8000 && k < n; i++)
      @(posedge clk_sys_i);
    if (k < n)
    begin
      err_total++;
      give_verdict();
    end
    $display("Test %s done at instruction %0d", nm, k);
  endtask
  // ==========================================================================
  // Main sequence
  initial
  begin
    int b1, b2, b3;
    logic [15:0] t;
    t = 16'($urandom(77));
    carry_i <= 1'($urandom);
    bit_val_i <= 1'b1;
    for (int i = 0; i < 4096; i++)
      far.code_q[i] = 8'h00;
    @(posedge clk_sys_i);
    foreach (tbl[i])
      emit(tbl[i][15:8], 8'($urandom), 8'($urandom), tbl[i][5:4], 2'h0, tbl[i][3:0]);
    b1 = qa.size();
    for (int i = 0; i < 40; i++)
    begin
      t = tbl[$urandom_range(66)];
      emit(t[15:8], 8'($urandom), 8'($urandom), t[5:4], 2'h0, t[3:0]);
    end
    b2 = qa.size();
    // Back-to-back bit writes on ports and plain bits, then jumps on a bit
    foreach (bops[i])
    begin
      bitop(bops[i], 8'h80 | 8'($urandom_range(7)));
      bitop(bops[i], 8'h20 | 8'($urandom_range(7)));
    end
    bitop(`CIT_OP_SET_BIT, 8'h83);
    bit_jump(8'h83);
    bit_jump(8'h83);
    bit_jump(8'h20);
    b3 = qa.size();
    repeat (3) emit(8'h00, 8'h00, 8'h00, 2'h1, 2'h0, 4'h1);
    emit(8'hA5, 8'h00, 8'h00, 2'h1, 2'h0, 4'h1);
    emit(`CIT_OP_AND_DIR_A, 8'h90, 8'h00, 2'h2, 2'h1, 4'h2);
    emit(8'h00, 8'h00, 8'h00, 2'h1, 2'h0, 4'h1);
    emit(8'hE5, 8'h90, 8'h00, 2'h2, 2'h2, 4'h2);
    repeat (4) emit(8'h00, 8'h00, 8'h00, 2'h1, 2'h0, 4'h1);
    pin <= ~lat_exp;
    repeat (19) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    run_to(b1, "timing table");
    run_to(b2, "random program");
    run_to(b3, "bit writes");
    run_to(qa.size() - 1, "port reads");
    give_verdict();
  end
endmodule // cit_instr_seq_tb
`default_nettype wire
